// ### dv/conv_sequencer_model.sv
module conv_sequencer_model
  import monitor_pkg::*;
(
  input  wire logic         clk_i,
  output logic              conv_valid_o,
  output logic              conv_is_temp_o,
  output logic [CHAN_W-1:0] conv_chan_o,
  output logic [VOLT_W-1:0] conv_data_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // Sample source; strobe stays up across back-to-back samples
  // ****
  initial
  begin
    conv_valid_o   = 1'b0;
    conv_is_temp_o = 1'b0;
    conv_chan_o    = '0;
    conv_data_o    = '0;
  end
  task automatic send(input logic t, input logic [CHAN_W-1:0] c, input logic [VOLT_W-1:0] d);
    conv_valid_o   <= 1'b1;
    conv_is_temp_o <= t;
    conv_chan_o    <= c;
    conv_data_o    <= d;
    @(posedge clk_i);
  endtask
  // Idle data inverted, so stale data never passes as a sample
  task automatic rest(input int n);
    conv_valid_o <= 1'b0;
    conv_data_o  <= ~conv_data_o;
    repeat (n) @(posedge clk_i);
  endtask
endmodule

// ### dv/monitor_channel_postproc_properties.sv
module postproc_properties
  import monitor_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rstn_i,
  input wire logic        conv_valid_i,
  input wire logic        conv_is_temp_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  input wire logic        overheat_alarm_o,
  input wire logic        system_reset_request_o
);
  // ****
  // Recent causes: alarm pins never move on their own
  // ****
  logic [4:0] temp_q;
  logic [4:0] wr_q;
  logic       wrote_q;
  wire        cause = (|temp_q[4:1]) || (|wr_q);
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      temp_q  <= '0;
      wr_q    <= '0;
      wrote_q <= 1'b0;
    end
    else
    begin
      temp_q  <= {temp_q[3:0], conv_valid_i && conv_is_temp_i};
      wr_q    <= {wr_q[3:0], avs_write_i};
      wrote_q <= wrote_q | avs_write_i;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  sequence req_open;
    (avs_read_i || avs_write_i) && avs_waitrequest_o;
  endsequence
  sequence one_answer;
    !avs_waitrequest_o ##1 avs_waitrequest_o;
  endsequence
  bus_answer_a: assert property (req_open |=> one_answer)
    else $error("bus answer not one cycle after request");
  bus_idle_a: assert property (
    !(avs_read_i || avs_write_i) && avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("bus answer without request");
  wait_short_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low too long");
  read_hold_a: assert property (
    !$stable(avs_readdata_o) |-> !avs_waitrequest_o && $past(avs_read_i))
    else $error("readdata moved outside a read answer");
  reset_state_a: assert property (disable iff (1'b0) !rstn_i |=> avs_waitrequest_o
    && avs_readdata_o == 32'h0000_0000 && !overheat_alarm_o && !system_reset_request_o)
    else $error("outputs not cleared by reset");
  heat_cause_a: assert property ($changed(overheat_alarm_o) |-> cause)
    else $error("overheat output moved without cause");
  rst_cause_a: assert property ($changed(system_reset_request_o) |-> cause)
    else $error("reset request moved without cause");
  default_link_a: assert property (!wrote_q |-> overheat_alarm_o == system_reset_request_o)
    else $error("default reset request differs from overheat");
endmodule

bind monitor_channel_postproc postproc_properties postproc_properties_inst (
  .clk_i, .rstn_i, .conv_valid_i, .conv_is_temp_i, .avs_read_i, .avs_write_i,
  .avs_readdata_o, .avs_waitrequest_o, .overheat_alarm_o, .system_reset_request_o);

// ### dv/tb_monitor_channel_postproc.sv
module tb_monitor_channel_postproc
  import monitor_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // Signals and tables
  // ****
  logic              clk_i            = 1'b0;
  logic              rstn_i           = 1'b0;
  logic [ADDR_W-1:0] avs_address_i    = '0;
  logic              avs_read_i       = 1'b0;
  logic              avs_write_i      = 1'b0;
  logic [31:0]       avs_writedata_i  = '0;
  logic [3:0]        avs_byteenable_i = 4'hF;
  logic [31:0]       avs_readdata_o;
  logic              avs_waitrequest_o;
  logic              overheat_alarm_o;
  logic              system_reset_request_o;
  logic              conv_valid_i;
  logic              conv_is_temp_i;
  logic [CHAN_W-1:0] conv_chan_i;
  logic [VOLT_W-1:0] conv_data_i;
  int                err_count        = 0;
  int                tests_run        = 0;
  logic [15:0]       temps [7]        = '{16'h1100, 16'h0900, 16'h0600, 16'hFF00,
                                          16'h0B00, 16'h1100, 16'h1100};
  logic [1:0]        cfgs [7]         = '{2'h3, 2'h3, 2'h3, 2'h3, 2'h3, 2'h2, 2'h1};
  logic [VOLT_W-1:0] va [4]           = '{19'h7_0000, 19'h5_0000, 19'h0_8000, 19'h5_0000};
  logic [VOLT_W-1:0] vb [4]           = '{19'h0_0000, 19'h5_0000, 19'h0_8000, 19'h5_0000};
  always #50 clk_i = ~clk_i;
  conv_sequencer_model conv_sequencer_model_inst (.clk_i, .conv_valid_o(conv_valid_i),
    .conv_is_temp_o(conv_is_temp_i), .conv_chan_o(conv_chan_i), .conv_data_o(conv_data_i));
  monitor_channel_postproc monitor_channel_postproc_inst (.clk_i, .rstn_i, .conv_valid_i,
    .conv_is_temp_i, .conv_chan_i, .conv_data_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
    .overheat_alarm_o, .system_reset_request_o);
  function automatic logic [ADDR_W-1:0] ca(input logic [3:0] r, input int c);
    return {r, 8'(c), 2'b00};
  endfunction
  function automatic logic [ADDR_W-1:0] bk(input logic [8:0] g, input int c);
    return {g, 3'(c / 32), 2'b00};
  endfunction
  function automatic logic [31:0] mean(input logic [31:0] s, input int l);
    return s >> (l + 1);
  endfunction
  function automatic logic hyst(input logic a, input logic signed [15:0] t,
                                input logic signed [15:0] hi, input logic signed [15:0] lo);
    return (t > hi) ? 1'b1 : ((t < lo) ? 1'b0 : a);
  endfunction
  task automatic end_sim();
    if (err_count == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  // Idle edge between accesses
  task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    avs_read_i      <= !w;
    avs_write_i     <= w;
    avs_address_i   <= a;
    avs_writedata_i <= d;
    do
      @(posedge clk_i);
    while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_read_i  <= 1'b0;
    avs_write_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] m,
                        input logic [31:0] e, input string n);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    chk(n, e & m, q & m);
  endtask
  task automatic wrr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic smp(input logic t, input int c, input logic [VOLT_W-1:0] d);
    conv_sequencer_model_inst.send(t, 8'(c), d);
  endtask
  initial
  begin
    repeat (30000) @(posedge clk_i);
    err_count++;
    end_sim();
  end
  initial
  begin
    logic [VOLT_W-1:0] v, mx, mn, p;
    logic [31:0]       s, b;
    int                c, l, k;
    logic              de, oe;
    void'($urandom(32'h148f));
    repeat (3) @(posedge clk_i);
    rstn_i <= 1'b1;
    @(posedge clk_i);
    rd_chk(OFS_ALARM_CONFIG, '1, 32'h0000_0003, "alarm_cfg");
    rd_chk(ca(REG_HIGH, 159), '1, 32'h0007_FFFF, "high_lim");
    rd_chk(14'h3FFC, '1, 32'h0000_0000, "unmapped");
    c = $urandom_range(158);
    b = 32'h0000_0001 << (c % 32);
    mx = '0;
    mn = '1;
    repeat (4)
    begin
      v = 19'($urandom);
      mx = (v > mx) ? v : mx;
      mn = (v < mn) ? v : mn;
      smp(1'b0, c, v);
    end
    smp(1'b0, c + 1, v);
    smp(1'b0, 200, 19'h0_0000);
    conv_sequencer_model_inst.rest(2);
    rd_chk(ca(REG_RESULT, c), '1, 32'(v), "result");
    rd_chk(ca(REG_PEAK, c), '1, 32'(mx), "peak");
    rd_chk(ca(REG_TROUGH, c), '1, 32'(mn), "trough");
    wrr(bk(GRP_HIST_RESET, c), b);
    rd_chk(ca(REG_PEAK, c), '1, 32'h0000_0000, "peak_clr");
    rd_chk(ca(REG_PEAK, c + 1), '1, 32'(v), "peak_kept");
    wrr(bk(GRP_AVG_EN, c), b);
    p = v;
    mx = '0;
    mn = '1;
    for (l = 0; l < 4; l++)
    begin
      wrr(OFS_CONFIG, 32'(l));
      s = '0;
      for (k = 0; k < (2 << l); k++)
      begin
        v = 19'($urandom);
        s += 32'(v);
        smp(1'b0, c, v);
        if (k == (2 << l) - 2)
        begin
          conv_sequencer_model_inst.rest(2);
          rd_chk(ca(REG_RESULT, c), '1, 32'(p), "avg_hold");
        end
      end
      conv_sequencer_model_inst.rest(2);
      p = 19'(mean(s, l));
      mx = (p > mx) ? p : mx;
      mn = (p < mn) ? p : mn;
      rd_chk(ca(REG_RESULT, c), '1, 32'(p), "avg_done");
    end
    rd_chk(ca(REG_PEAK, c), '1, 32'(mx), "avg_peak");
    rd_chk(ca(REG_TROUGH, c), '1, 32'(mn), "avg_trough");
    wrr(OFS_CONFIG, 32'h0000_0000);
    wrr(ca(REG_HIGH, c), 32'h0004_0000);
    wrr(ca(REG_LOW, c), 32'h0001_0000);
    for (k = 0; k < 4; k++)
    begin
      wrr(bk(GRP_ALARM_EN, c), (k < 3) ? b : 32'h0000_0000);
      wrr(bk(GRP_ALARM_FLAG, c), b);
      wrr(OFS_INT_STATUS, 32'h0000_0004);
      smp(1'b0, c, va[k]);
      smp(1'b0, c, vb[k]);
      conv_sequencer_model_inst.rest(2);
      s = mean(32'(va[k]) + 32'(vb[k]), 0);
      s = (k < 3 && (s > 32'h0004_0000 || s < 32'h0001_0000)) ? '1 : '0;
      rd_chk(bk(GRP_ALARM_FLAG, c), b, s, "flag");
      rd_chk(OFS_INT_STATUS, 32'h0000_0004, s, "isr_volt");
    end
    wrr(OFS_CONFIG, 32'h0000_0003);
    wrr(OFS_DIE_TRIP, 32'h0000_0C00);
    wrr(OFS_DIE_RELEASE, 32'h0000_0400);
    wrr(OFS_OVH_TRIP, 32'h0000_1000);
    wrr(OFS_OVH_RELEASE, 32'h0000_0800);
    de = 1'b0;
    oe = 1'b0;
    for (k = 0; k < 7; k++)
    begin
      wrr(OFS_ALARM_CONFIG, 32'(cfgs[k]));
      smp(1'b1, 0, 19'(temps[k]));
      conv_sequencer_model_inst.rest(4);
      de = hyst(de, temps[k], 16'h0C00, 16'h0400);
      oe = hyst(oe, temps[k], 16'h1000, 16'h0800);
      rd_chk(OFS_TEMP_NOW, 32'h0000_FFFF, 32'(temps[k]), "temp_now");
      rd_chk(OFS_TEMP_ALARM, 32'h0000_0003, {30'h0, oe, de}, "alarm");
      rd_chk(OFS_INT_STATUS, 32'h0000_0003, 32'h0000_0003, "isr_temp");
      chk("heat_pin", 32'(oe & cfgs[k][0]), 32'(overheat_alarm_o));
      chk("reset_pin", 32'(oe & cfgs[k][0] & cfgs[k][1]), 32'(system_reset_request_o));
    end
    end_sim();
  end
endmodule

// ### hw/heat_hysteresis.sv
module heat_hysteresis
  import monitor_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rstn_i,
  input  wire logic              valid_i,
  input  wire logic [TEMP_W-1:0] sample_i,
  input  wire logic [TEMP_W-1:0] trip_i,
  input  wire logic [TEMP_W-1:0] release_i,
  output logic                   alarm_o
);
  // Signed, like the stored readings
  wire logic above = $signed(sample_i) > $signed(trip_i);
  wire logic below = $signed(sample_i) < $signed(release_i);

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      alarm_o <= 1'b0;
    else if (valid_i && above)
      alarm_o <= 1'b1;
    else if (valid_i && below)
      alarm_o <= 1'b0;
  end
endmodule

// ### hw/monitor_channel_postproc.sv
// Notes on behaviour
// - Averaging enabled per channel; one shared level of 2, 4, 8 or 16 samples.
// - Averaged channel result is written only when a full sequence completes.
// - Alarms and other consumers see only the averaged value when averaging.
// - Temperature channel ignores voltage averaging enables and level.
// - Each channel keeps peak and trough values seen since last reset.
// - Averaged channels update peak and trough only with completed averages.
// - History reset write clears only the selected channels' peak and trough.
// - Two temperature alarms and 160 voltage alarms with programmable levels.
// - Window alarm asserts above high limit or below low limit.
// - Each voltage channel has own high and low limits plus enables.
// - Only enabled voltage alarms set bits in readable flag banks and raise status.
// - Hysteresis alarm sets above trip limit, clears only below release limit.
// - Temperature alarms always enabled, own register, set interrupt status.
// - Die and overheat alarms each use their own trip and release limits.
// - With shutdown enabled, overheat above trip drives the overheat output.
// - Alarm configuration controls overheat behaviour and shutdown enable.
// - By default an overheat alarm raises the system reset request.
// - Temperatures are signed Q8.7 in the low 16 bits.
// - Voltage results and limits are unsigned in the low 19 bits.
//
// The register offsets and the Avalon-MM register port were left to the implementer.
module monitor_channel_postproc
  import monitor_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rstn_i,
  input  wire logic              conv_valid_i,
  input  wire logic              conv_is_temp_i,
  input  wire logic [CHAN_W-1:0] conv_chan_i,
  input  wire logic [VOLT_W-1:0] conv_data_i,
  input  wire logic [ADDR_W-1:0] avs_address_i,
  input  wire logic              avs_read_i,
  input  wire logic              avs_write_i,
  input  wire logic [31:0]       avs_writedata_i,
  input  wire logic [3:0]        avs_byteenable_i,
  output logic [31:0]            avs_readdata_o,
  output logic                   avs_waitrequest_o,
  output logic                   overheat_alarm_o,
  output logic                   system_reset_request_o
);
  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    return (old & ~m) | (wd & m);
  endfunction

  function automatic logic in_region(input logic [ADDR_W-1:0] a, input logic [3:0] r);
    return (a[13:10] == r) && (a[9:2] < CHAN_W'(NUM_CHAN));
  endfunction

  // ****************************************
  // State
  // ****************************************
  bus_state_t        bus_q;
  logic [1:0]        cfg_avg_q;
  logic [1:0]        acfg_q;
  logic [2:0]        isr_q;
  logic [TEMP_W-1:0] temp_now_q, temp_peak_q, temp_trough_q;
  logic              temp_seen_q, temp_upd_q;
  logic [TEMP_W-1:0] die_rel_q, die_trip_q, ovh_rel_q, ovh_trip_q;
  logic              die_lvl_d, ovh_lvl_d, die_prev_q, ovh_prev_q;
  logic [NUM_CHAN-1:0] avg_en_q, alm_en_q, alm_flag_q, seen_q;
  logic [VOLT_W-1:0] result_q [NUM_CHAN];
  logic [VOLT_W-1:0] peak_q   [NUM_CHAN];
  logic [VOLT_W-1:0] trough_q [NUM_CHAN];
  logic [VOLT_W-1:0] high_q   [NUM_CHAN];
  logic [VOLT_W-1:0] low_q    [NUM_CHAN];

  // ****************************************
  // Bus decode
  // ****************************************
  wire logic              wr_fire = (bus_q == BUS_DONE) && avs_write_i;
  wire logic [8:0]        grp     = avs_address_i[13:5];
  wire logic [2:0]        bank    = avs_address_i[4:2];
  wire logic              bank_ok = bank < 3'(BANKS);
  wire logic [CHAN_W-1:0] ch      = avs_address_i[9:2];
  wire logic [31:0]       w1c     = merge(32'h0000_0000, avs_writedata_i, avs_byteenable_i);
  wire logic [NUM_CHAN-1:0] bank_wr_mask = bank_ok
    ? NUM_CHAN'({128'h0, 32'hFFFF_FFFF} << (32 * bank)) : '0;
  wire logic [NUM_CHAN-1:0] bank_wr_data = NUM_CHAN'({128'h0, w1c} << (32 * bank));
  wire logic [NUM_CHAN-1:0] hist_clr = (wr_fire && grp == GRP_HIST_RESET)
    ? (bank_wr_data & bank_wr_mask) : '0;
  wire logic [NUM_CHAN-1:0] flag_clr = (wr_fire && grp == GRP_ALARM_FLAG)
    ? (bank_wr_data & bank_wr_mask) : '0;
  wire logic wr_cfg  = wr_fire && avs_address_i == OFS_CONFIG;
  wire logic wr_acfg = wr_fire && avs_address_i == OFS_ALARM_CONFIG;
  wire logic wr_isr  = wr_fire && avs_address_i == OFS_INT_STATUS;
  wire logic wr_high = wr_fire && in_region(avs_address_i, REG_HIGH);
  wire logic wr_low  = wr_fire && in_region(avs_address_i, REG_LOW);

  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (avs_address_i)
      OFS_CONFIG:       rd_mux = 32'(cfg_avg_q);
      OFS_ALARM_CONFIG: rd_mux = 32'(acfg_q);
      OFS_INT_STATUS:   rd_mux = 32'(isr_q);
      OFS_TEMP_NOW:     rd_mux = 32'(temp_now_q);
      OFS_TEMP_PEAK:    rd_mux = 32'(temp_peak_q);
      OFS_TEMP_TROUGH:  rd_mux = 32'(temp_trough_q);
      OFS_DIE_RELEASE:  rd_mux = 32'(die_rel_q);
      OFS_DIE_TRIP:     rd_mux = 32'(die_trip_q);
      OFS_OVH_RELEASE:  rd_mux = 32'(ovh_rel_q);
      OFS_OVH_TRIP:     rd_mux = 32'(ovh_trip_q);
      OFS_TEMP_ALARM:   rd_mux = {30'h0, ovh_prev_q, die_prev_q};
      default:
      begin
        if (bank_ok && grp == GRP_AVG_EN)
          rd_mux = avg_en_q[32*bank +: 32];
        else if (bank_ok && grp == GRP_ALARM_EN)
          rd_mux = alm_en_q[32*bank +: 32];
        else if (bank_ok && grp == GRP_ALARM_FLAG)
          rd_mux = alm_flag_q[32*bank +: 32];
        else if (in_region(avs_address_i, REG_RESULT))
          rd_mux = 32'(result_q[ch]);
        else if (in_region(avs_address_i, REG_PEAK))
          rd_mux = 32'(peak_q[ch]);
        else if (in_region(avs_address_i, REG_TROUGH))
          rd_mux = 32'(trough_q[ch]);
        else if (in_region(avs_address_i, REG_HIGH))
          rd_mux = 32'(high_q[ch]);
        else if (in_region(avs_address_i, REG_LOW))
          rd_mux = 32'(low_q[ch]);
      end
    endcase
  end

  // ****************************************
  // Bus handshake: one wait state, then answer
  // ****************************************
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      bus_q             <= BUS_IDLE;
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= '0;
    end
    else
    begin
      case (bus_q)
        BUS_IDLE:
        begin
          if (avs_read_i || avs_write_i)
          begin
            bus_q             <= BUS_DONE;
            avs_waitrequest_o <= 1'b0;
            avs_readdata_o    <= avs_read_i ? rd_mux : avs_readdata_o;
          end
        end
        default:
        begin
          bus_q             <= BUS_IDLE;
          avs_waitrequest_o <= 1'b1;
        end
      endcase
    end
  end

  // ****************************************
  // Averaging (voltage channels only)
  // ****************************************
  logic              av_valid;
  logic [CHAN_W-1:0] av_chan;
  logic [VOLT_W-1:0] av_data;
  wire logic volt_in = conv_valid_i && !conv_is_temp_i;

  sample_averager u_avg (
    .clk_i       (clk_i),
    .rstn_i      (rstn_i),
    .in_valid_i  (volt_in),
    .in_chan_i   (conv_chan_i),
    .in_data_i   (conv_data_i),
    .avg_en_i    (avg_en_q[conv_chan_i]),
    .level_i     (cfg_avg_q),
    .out_valid_o (av_valid),
    .out_chan_o  (av_chan),
    .out_data_o  (av_data)
  );

  // ****************************************
  // Per-channel history, limits and window alarms
  // ****************************************
  wire logic [NUM_CHAN-1:0] flag_set;
  genvar g;
  generate
    for (g = 0; g < NUM_CHAN; g++)
    begin : g_chan
      wire logic hit = av_valid && av_chan == CHAN_W'(g);
      wire logic out_win = (av_data > high_q[g]) || (av_data < low_q[g]);
      assign flag_set[g] = hit && alm_en_q[g] && out_win;
      always_ff @(posedge clk_i)
      begin
        if (!rstn_i)
        begin
          result_q[g] <= '0;
          peak_q[g]   <= '0;
          trough_q[g] <= '0;
          seen_q[g]   <= 1'b0;
          high_q[g]   <= HIGH_LIMIT_RST;
          low_q[g]    <= LOW_LIMIT_RST;
        end
        else
        begin
          if (wr_high && ch == CHAN_W'(g))
            high_q[g] <= VOLT_W'(merge(32'(high_q[g]), avs_writedata_i,
                                       avs_byteenable_i));
          if (wr_low && ch == CHAN_W'(g))
            low_q[g] <= VOLT_W'(merge(32'(low_q[g]), avs_writedata_i,
                                      avs_byteenable_i));
          if (hit)
          begin
            result_q[g] <= av_data;
            seen_q[g]   <= 1'b1;
            // First sample after a reset seeds both ends
            if (!seen_q[g] || hist_clr[g] || av_data > peak_q[g])
              peak_q[g] <= av_data;
            if (!seen_q[g] || hist_clr[g] || av_data < trough_q[g])
              trough_q[g] <= av_data;
          end
          else if (hist_clr[g])
          begin
            seen_q[g]   <= 1'b0;
            peak_q[g]   <= '0;
            trough_q[g] <= '0;
          end
        end
      end
    end
  endgenerate

  // ****************************************
  // Temperature path: never averaged
  // ****************************************
  wire logic [TEMP_W-1:0] tsamp = conv_data_i[TEMP_W-1:0];
  wire logic temp_in = conv_valid_i && conv_is_temp_i;

  heat_hysteresis u_die (
    .clk_i     (clk_i),
    .rstn_i    (rstn_i),
    .valid_i   (temp_upd_q),
    .sample_i  (temp_now_q),
    .trip_i    (die_trip_q),
    .release_i (die_rel_q),
    .alarm_o   (die_lvl_d)
  );

  heat_hysteresis u_ovh (
    .clk_i     (clk_i),
    .rstn_i    (rstn_i),
    .valid_i   (temp_upd_q),
    .sample_i  (temp_now_q),
    .trip_i    (ovh_trip_q),
    .release_i (ovh_rel_q),
    .alarm_o   (ovh_lvl_d)
  );

  wire logic [2:0] isr_set = {|flag_set, ovh_lvl_d & ~ovh_prev_q,
                              die_lvl_d & ~die_prev_q};

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      cfg_avg_q <= CFG_AVG_RST;
      acfg_q    <= ACFG_RST;
      isr_q     <= '0;
      avg_en_q  <= '0;
      alm_en_q  <= '0;
      alm_flag_q <= '0;
      die_rel_q <= DIE_RELEASE_RST;
      die_trip_q <= DIE_TRIP_RST;
      ovh_rel_q <= OVH_RELEASE_RST;
      ovh_trip_q <= OVH_TRIP_RST;
      temp_now_q <= '0;
      temp_peak_q <= '0;
      temp_trough_q <= '0;
      temp_seen_q <= 1'b0;
      temp_upd_q <= 1'b0;
      die_prev_q <= 1'b0;
      ovh_prev_q <= 1'b0;
    end
    else
    begin
      if (wr_cfg)
        cfg_avg_q <= w1c[CFG_AVG_LSB +: 2];
      if (wr_acfg)
        acfg_q <= 2'(merge(32'(acfg_q), avs_writedata_i, avs_byteenable_i));
      // Set wins over a same-cycle clear
      isr_q      <= (isr_q & ~(wr_isr ? w1c[2:0] : 3'h0)) | isr_set;
      alm_flag_q <= (alm_flag_q & ~flag_clr) | flag_set;
      if (wr_fire && grp == GRP_AVG_EN)
        avg_en_q <= (avg_en_q & ~bank_wr_mask) | (bank_wr_data & bank_wr_mask);
      if (wr_fire && grp == GRP_ALARM_EN)
        alm_en_q <= (alm_en_q & ~bank_wr_mask) | (bank_wr_data & bank_wr_mask);
      if (wr_fire && avs_address_i == OFS_DIE_RELEASE)
        die_rel_q <= TEMP_W'(merge(32'(die_rel_q), avs_writedata_i, avs_byteenable_i));
      if (wr_fire && avs_address_i == OFS_DIE_TRIP)
        die_trip_q <= TEMP_W'(merge(32'(die_trip_q), avs_writedata_i, avs_byteenable_i));
      if (wr_fire && avs_address_i == OFS_OVH_RELEASE)
        ovh_rel_q <= TEMP_W'(merge(32'(ovh_rel_q), avs_writedata_i, avs_byteenable_i));
      if (wr_fire && avs_address_i == OFS_OVH_TRIP)
        ovh_trip_q <= TEMP_W'(merge(32'(ovh_trip_q), avs_writedata_i, avs_byteenable_i));
      temp_upd_q <= temp_in;
      if (temp_in)
      begin
        temp_now_q  <= tsamp;
        temp_seen_q <= 1'b1;
        if (!temp_seen_q || $signed(tsamp) > $signed(temp_peak_q))
          temp_peak_q <= tsamp;
        if (!temp_seen_q || $signed(tsamp) < $signed(temp_trough_q))
          temp_trough_q <= tsamp;
      end
      die_prev_q <= die_lvl_d;
      ovh_prev_q <= ovh_lvl_d;
    end
  end

  // ****************************************
  // Overheat outputs
  // ****************************************
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      overheat_alarm_o       <= 1'b0;
      system_reset_request_o <= 1'b0;
    end
    else
    begin
      overheat_alarm_o       <= ovh_lvl_d && acfg_q[ACFG_SHDN_BIT];
      system_reset_request_o <= ovh_lvl_d && acfg_q[ACFG_SHDN_BIT]
                                && acfg_q[ACFG_RST_BIT];
    end
  end
endmodule

// ### hw/monitor_pkg.sv
package monitor_pkg;
  // ****************************************
  // Sizes
  // ****************************************
  localparam int NUM_CHAN = 160;
  localparam int CHAN_W   = 8;
  localparam int VOLT_W   = 19;
  localparam int TEMP_W   = 16;
  localparam int CNT_W    = 4;
  localparam int ACC_W    = VOLT_W + CNT_W;
  localparam int BANKS    = 5;
  localparam int ADDR_W   = 14;

  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam logic [ADDR_W-1:0] OFS_CONFIG       = 14'h0000;
  localparam logic [ADDR_W-1:0] OFS_ALARM_CONFIG = 14'h0004;
  localparam logic [ADDR_W-1:0] OFS_INT_STATUS   = 14'h0008;
  localparam logic [ADDR_W-1:0] OFS_TEMP_NOW     = 14'h000C;
  localparam logic [ADDR_W-1:0] OFS_TEMP_PEAK    = 14'h0010;
  localparam logic [ADDR_W-1:0] OFS_TEMP_TROUGH  = 14'h0014;
  localparam logic [ADDR_W-1:0] OFS_DIE_RELEASE  = 14'h0018;
  localparam logic [ADDR_W-1:0] OFS_DIE_TRIP     = 14'h001C;
  localparam logic [ADDR_W-1:0] OFS_OVH_RELEASE  = 14'h0020;
  localparam logic [ADDR_W-1:0] OFS_OVH_TRIP     = 14'h0024;
  localparam logic [ADDR_W-1:0] OFS_TEMP_ALARM   = 14'h0028;
  // Bank groups, selected by address bits [13:5], bank by [4:2]
  localparam logic [8:0] GRP_AVG_EN     = 9'h002;
  localparam logic [8:0] GRP_ALARM_EN   = 9'h003;
  localparam logic [8:0] GRP_ALARM_FLAG = 9'h004;
  localparam logic [8:0] GRP_HIST_RESET = 9'h005;
  // Per-channel regions, selected by address bits [13:10], channel by [9:2]
  localparam logic [3:0] REG_RESULT = 4'h4;
  localparam logic [3:0] REG_PEAK   = 4'h5;
  localparam logic [3:0] REG_TROUGH = 4'h6;
  localparam logic [3:0] REG_HIGH   = 4'h7;
  localparam logic [3:0] REG_LOW    = 4'h8;

  // ****************************************
  // Fields and reset values
  // ****************************************
  localparam int CFG_AVG_LSB   = 0;
  localparam int ACFG_SHDN_BIT = 0;
  localparam int ACFG_RST_BIT  = 1;
  localparam int ISR_DIE_BIT   = 0;
  localparam int ISR_OVH_BIT   = 1;
  localparam int ISR_VOLT_BIT  = 2;
  localparam logic [1:0]        CFG_AVG_RST     = 2'h0;
  localparam logic [1:0]        ACFG_RST        = 2'h3;
  localparam logic [TEMP_W-1:0] DIE_RELEASE_RST = 16'h2580;
  localparam logic [TEMP_W-1:0] DIE_TRIP_RST    = 16'h2A80;
  localparam logic [TEMP_W-1:0] OVH_RELEASE_RST = 16'h3700;
  localparam logic [TEMP_W-1:0] OVH_TRIP_RST    = 16'h3E80;
  localparam logic [VOLT_W-1:0] HIGH_LIMIT_RST  = 19'h7_FFFF;
  localparam logic [VOLT_W-1:0] LOW_LIMIT_RST   = 19'h0_0000;

  typedef enum logic {BUS_IDLE, BUS_DONE} bus_state_t;
endpackage

// ### hw/sample_averager.sv
module sample_averager
  import monitor_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rstn_i,
  input  wire logic              in_valid_i,
  input  wire logic [CHAN_W-1:0] in_chan_i,
  input  wire logic [VOLT_W-1:0] in_data_i,
  input  wire logic              avg_en_i,
  input  wire logic [1:0]        level_i,
  output logic                   out_valid_o,
  output logic [CHAN_W-1:0]      out_chan_o,
  output logic [VOLT_W-1:0]      out_data_o
);
  logic [ACC_W-1:0] acc_q [NUM_CHAN];
  logic [CNT_W-1:0] cnt_q [NUM_CHAN];

  wire logic [CNT_W-1:0] last_cnt = CNT_W'((5'd2 << level_i) - 5'd1);
  wire logic             in_range = in_chan_i < CHAN_W'(NUM_CHAN);
  wire logic [ACC_W-1:0] sum      = acc_q[in_chan_i] + ACC_W'(in_data_i);
  wire logic             seq_end  = cnt_q[in_chan_i] >= last_cnt;
  wire logic [VOLT_W-1:0] mean    = VOLT_W'(sum >> ({1'b0, level_i} + 3'd1));

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      out_valid_o <= 1'b0;
      out_chan_o  <= '0;
      out_data_o  <= '0;
      for (int i = 0; i < NUM_CHAN; i++)
      begin
        acc_q[i] <= '0;
        cnt_q[i] <= '0;
      end
    end
    else
    begin
      out_valid_o <= 1'b0;
      if (in_valid_i && in_range)
      begin
        out_chan_o <= in_chan_i;
        if (!avg_en_i || seq_end)
        begin
          out_valid_o      <= 1'b1;
          out_data_o       <= avg_en_i ? mean : in_data_i;
          acc_q[in_chan_i] <= '0;
          cnt_q[in_chan_i] <= '0;
        end
        else
        begin
          acc_q[in_chan_i] <= sum;
          cnt_q[in_chan_i] <= cnt_q[in_chan_i] + 1'b1;
        end
      end
    end
  end
endmodule
